// ### pkg/rtmc_map.vh
// Register offsets, field positions and reset values for the mode-code action block
`ifndef RTMC_MAP_VH
`define RTMC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTMC_ADDR_W        4
`define RTMC_OFF_OPTION    4'h0
`define RTMC_OFF_TTAG      4'h1
`define RTMC_OFF_STATUS    4'h2

// ----------------------------------------
// Option register fields
// ----------------------------------------
`define RTMC_RESET_OPT_BIT 0
`define RTMC_VEC_OPT_BIT   1
`define RTMC_SYNC_LSB      2
`define RTMC_SYNC_MSB      3
`define RTMC_OPTION_RST    4'h0

// ----------------------------------------
// Time-sync option encodings
// ----------------------------------------
`define RTMC_SYNC_ALWAYS   2'h0
`define RTMC_SYNC_BIT0_LO  2'h1
`define RTMC_SYNC_BIT0_HI  2'h2
`define RTMC_SYNC_HOST     2'h3

// ----------------------------------------
// Mode codes and counter reset
// ----------------------------------------
`define RTMC_CODE_RESET    5'h08
`define RTMC_CODE_SYNC     5'h11
`define RTMC_TTAG_RST      16'h0000

`endif

// ### rtl/rtmc_mode_actions.v
// Remote-terminal automatic actions for the reset and synchronize-with-data mode commands
// ----------------------------------------
// ----------------------------------------
//
// Local design decisions: the register addresses and strobed register access.
`include "rtmc_map.vh"

module rtmc_mode_actions #(
	parameter TTAG_W = 16
) (
	// Clock and reset
	input  wire                     ref_clk_i,
	input  wire                     sys_rst_i,
	// Register port
	input  wire [`RTMC_ADDR_W-1:0]  reg_addr_i,
	input  wire [15:0]              reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output reg  [15:0]              reg_rdata_o,
	// Decoded mode command from protocol engine
	input  wire                     mc_valid_i,
	input  wire [4:0]               mc_code_i,
	input  wire                     mc_bcast_i,
	input  wire [15:0]              mc_data_i,
	// Status word transmit handshake
	input  wire                     sw_tx_start_i,
	input  wire                     sw_tx_done_i,
	// Time tag, soft reset and status word hold
	input  wire                     ttag_tick_i,
	output reg  [TTAG_W-1:0]        ttag_count_o,
	output reg                      ttag_loaded_o,
	output reg                      terminal_soft_reset_o,
	output reg                      sw_tx_hold_o
);

	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	// One-hot, a stray code falls back to idle
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_WAIT = 2'b10;

	// ----------------------------------------
	// Registers and next values
	// ----------------------------------------
	reg  [1:0]        time_sync_load_option_q;
	reg  [1:0]        time_sync_load_option_d;
	reg               vector_word_service_clear_option_q;
	reg               vector_word_service_clear_option_d;
	reg               reset_command_manual_option_q;
	reg               reset_command_manual_option_d;
	reg  [TTAG_W-1:0] ttag_count_d;
	reg               ttag_loaded_d;
	reg               sw_tx_hold_d;
	reg  [1:0]        rst_state_q;
	reg  [1:0]        rst_state_d;
	reg               soft_reset_d;
	reg               sync_hits_q;
	reg               sync_hits_d;
	reg               reset_seen_q;
	reg               reset_seen_d;
	reg  [15:0]       reg_rdata_d;
	reg  [15:0]       ttag_wide;

	// Reset values split into fields, counter step
	wire [3:0]        opt_rst  = `RTMC_OPTION_RST;
	wire [15:0]       ttag_rst = `RTMC_TTAG_RST;
	wire [TTAG_W-1:0] ttag_one = {{(TTAG_W-1){1'b0}}, 1'b1};

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Register index match
	function addr_hit;
		input [`RTMC_ADDR_W-1:0] addr;
		input [`RTMC_ADDR_W-1:0] off;
		begin
			addr_hit = (addr == off);
		end
	endfunction

	// Mode code match on a valid command
	function code_hit;
		input       valid;
		input [4:0] code;
		input [4:0] want;
		begin
			code_hit = valid && (code == want);
		end
	endfunction

	// Decide whether a sync data word is loaded
	function sync_load_ok;
		input [1:0] opt;
		input       bit0;
		begin
			case (opt)
				`RTMC_SYNC_ALWAYS:  sync_load_ok = 1'b1;
				`RTMC_SYNC_BIT0_LO: sync_load_ok = ~bit0;
				`RTMC_SYNC_BIT0_HI: sync_load_ok = bit0;
				default:            sync_load_ok = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Command and register decode
	// ----------------------------------------
	// Command strobes
	wire sync_cmd  = code_hit(mc_valid_i, mc_code_i, `RTMC_CODE_SYNC);
	wire reset_cmd = code_hit(mc_valid_i, mc_code_i, `RTMC_CODE_RESET);
	wire sync_load = sync_cmd && sync_load_ok(time_sync_load_option_q, mc_data_i[0]);
	wire auto_rst  = reset_cmd && !reset_command_manual_option_q;

	// Register strobes
	wire opt_wr    = reg_wr_i && addr_hit(reg_addr_i, `RTMC_OFF_OPTION);
	wire ttag_wr   = reg_wr_i && addr_hit(reg_addr_i, `RTMC_OFF_TTAG);
	wire stat_rd   = reg_rd_i && addr_hit(reg_addr_i, `RTMC_OFF_STATUS);

	// ----------------------------------------
	// Option register
	// ----------------------------------------
	// Host write replaces all option fields at once
	always @* begin
		time_sync_load_option_d            = time_sync_load_option_q;
		vector_word_service_clear_option_d = vector_word_service_clear_option_q;
		reset_command_manual_option_d      = reset_command_manual_option_q;
		if (opt_wr) begin
			time_sync_load_option_d            = reg_wdata_i[`RTMC_SYNC_MSB:`RTMC_SYNC_LSB];
			vector_word_service_clear_option_d = reg_wdata_i[`RTMC_VEC_OPT_BIT];
			reset_command_manual_option_d      = reg_wdata_i[`RTMC_RESET_OPT_BIT];
		end
	end

	// Option flops; cleared so MC8 handling starts automatic
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			time_sync_load_option_q            <= opt_rst[`RTMC_SYNC_MSB:`RTMC_SYNC_LSB];
			vector_word_service_clear_option_q <= opt_rst[`RTMC_VEC_OPT_BIT];
			reset_command_manual_option_q      <= opt_rst[`RTMC_RESET_OPT_BIT];
		end else begin
			time_sync_load_option_q            <= time_sync_load_option_d;
			vector_word_service_clear_option_q <= vector_word_service_clear_option_d;
			reset_command_manual_option_q      <= reset_command_manual_option_d;
		end
	end

	// ----------------------------------------
	// Time tag counter
	// ----------------------------------------
	// Sync load wins over host write, host write over tick
	always @* begin
		ttag_count_d  = ttag_count_o;
		ttag_loaded_d = sync_load;
		if (sync_load) begin
			ttag_count_d = mc_data_i[TTAG_W-1:0];
		end else if (ttag_wr) begin
			ttag_count_d = reg_wdata_i[TTAG_W-1:0];
		end else if (ttag_tick_i) begin
			ttag_count_d = ttag_count_o + ttag_one;
		end
	end

	// Load lands at the decode edge, ahead of any status transmit
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ttag_count_o  <= ttag_rst[TTAG_W-1:0];
			ttag_loaded_o <= 1'b0;
		end else begin
			ttag_count_o  <= ttag_count_d;
			ttag_loaded_o <= ttag_loaded_d;
		end
	end

	// ----------------------------------------
	// Status word hold
	// ----------------------------------------
	// Non-broadcast sync holds the status word one cycle
	always @* begin
		sw_tx_hold_d = sync_cmd && !mc_bcast_i;
	end

	// Hold pulse flop
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sw_tx_hold_o <= 1'b0;
		end else begin
			sw_tx_hold_o <= sw_tx_hold_d;
		end
	end

	// ----------------------------------------
	// Soft reset sequencer
	// ----------------------------------------
	// Non-broadcast MC8 waits for the status word; broadcast skips it
	always @* begin
		rst_state_d = rst_state_q;
		case (rst_state_q)
			ST_IDLE: begin
				if (auto_rst && !mc_bcast_i) begin
					rst_state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sw_tx_done_i) begin
					rst_state_d = ST_IDLE;
				end
			end
			default: rst_state_d = ST_IDLE;
		endcase
	end

	// One-cycle pulse: broadcast at once, otherwise after status word done
	always @* begin
		soft_reset_d = 1'b0;
		if (rst_state_q == ST_IDLE && auto_rst && mc_bcast_i) begin
			soft_reset_d = 1'b1;
		end else if (rst_state_q == ST_WAIT && sw_tx_done_i) begin
			soft_reset_d = 1'b1;
		end
	end

	// Sequencer and pulse flops
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rst_state_q           <= ST_IDLE;
			terminal_soft_reset_o <= 1'b0;
		end else begin
			rst_state_q           <= rst_state_d;
			terminal_soft_reset_o <= soft_reset_d;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Sticky, cleared by a status read; a new event wins
	always @* begin
		sync_hits_d  = sync_hits_q;
		reset_seen_d = reset_seen_q;
		if (stat_rd) begin
			sync_hits_d  = 1'b0;
			reset_seen_d = 1'b0;
		end
		if (sync_load) begin
			sync_hits_d = 1'b1;
		end
		if (reset_cmd) begin
			reset_seen_d = 1'b1;
		end
	end

	// Flag flops
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sync_hits_q  <= 1'b0;
			reset_seen_q <= 1'b0;
		end else begin
			sync_hits_q  <= sync_hits_d;
			reset_seen_q <= reset_seen_d;
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	// Time tag zero-extended to the bus word
	always @* begin
		ttag_wide               = 16'h0000;
		ttag_wide[TTAG_W-1:0]   = ttag_count_o;
	end

	// Read mux; unmapped indices and idle cycles give zero
	always @* begin
		reg_rdata_d = 16'h0000;
		if (reg_rd_i) begin
			if (addr_hit(reg_addr_i, `RTMC_OFF_OPTION)) begin
				reg_rdata_d = {12'h000, time_sync_load_option_q,
				               vector_word_service_clear_option_q, reset_command_manual_option_q};
			end else if (addr_hit(reg_addr_i, `RTMC_OFF_TTAG)) begin
				reg_rdata_d = ttag_wide;
			end else if (addr_hit(reg_addr_i, `RTMC_OFF_STATUS)) begin
				reg_rdata_d = {13'h0, rst_state_q == ST_WAIT, reset_seen_q, sync_hits_q};
			end
		end
	end

	// Read data stands the cycle after the strobe only
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			reg_rdata_o <= reg_rdata_d;
		end
	end

	// sw_tx_start_i is accepted for engine symmetry; the load never waits on it
	wire unused_ok = sw_tx_start_i;

endmodule

// ### test/rtmc_mode_actions_props.sv
// Checker for the mode-code action block
module rtmc_props #(parameter TTAG_W = 16) (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire [3:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire mc_valid_i,
	input wire [4:0] mc_code_i,
	input wire mc_bcast_i,
	input wire [15:0] mc_data_i,
	input wire sw_tx_done_i,
	input wire [TTAG_W-1:0] ttag_count_o,
	input wire ttag_loaded_o,
	input wire terminal_soft_reset_o,
	input wire sw_tx_hold_o
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [3:0] opt_q;
	wire s = mc_valid_i && mc_code_i == 5'h11;
	wire m = mc_valid_i && mc_code_i == 5'h08 && !sw_tx_done_i;
	wire r = mc_valid_i && mc_code_i == 5'h08 && !opt_q[0] && mc_bcast_i;
	wire [1:0] so = opt_q[3:2];
	// Shadow of the option register
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) opt_q <= 4'h0;
		else if (reg_wr_i && reg_addr_i == 4'h0) opt_q <= reg_wdata_i[3:0];
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_sync_lo: assert property (s && so == 2'h1 |=> ttag_loaded_o == !$past(mc_data_i[0]))
		else $error("sync 01 load wrong");
	a_sync_hi: assert property (s && so == 2'h2 |=> ttag_loaded_o == $past(mc_data_i[0]))
		else $error("sync 10 load wrong");
	a_load_first: assert property (s && !mc_bcast_i && so == 2'h0 |=> ttag_loaded_o && sw_tx_hold_o)
		else $error("load not before status");
	a_sync_always: assert property (s && so == 2'h0 |=> ttag_count_o == $past(mc_data_i))
		else $error("sync 00 no load");
	a_sync_host: assert property (s && so == 2'h3 |=> !ttag_loaded_o)
		else $error("sync 11 loaded");
	a_reset_bcast: assert property (r |=> terminal_soft_reset_o)
		else $error("no soft reset");
	a_reset_order: assert property (terminal_soft_reset_o |-> $past(sw_tx_done_i) || $past(r))
		else $error("soft reset too early");
	a_opt_read: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o == {12'h0, $past(opt_q)})
		else $error("option readback wrong");
	a_reset_wait: assert property (m && !mc_bcast_i && !opt_q[0] |=> !terminal_soft_reset_o)
		else $error("reset before status word");
	a_manual_quiet: assert property (m && opt_q[0] |=> !terminal_soft_reset_o)
		else $error("reset in manual mode");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data without read");
endmodule

bind rtmc_mode_actions rtmc_props #(.TTAG_W(TTAG_W)) u_props (.*);

// ### test/rtmc_bc_model.sv
// Bus controller model issuing mode commands
module rtmc_bc_model (
	input  wire         ref_clk_i,
	output logic        valid_o,
	output logic [4:0]  code_o,
	output logic        bcast_o,
	output logic [15:0] data_o,
	output logic        done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {valid_o, code_o, bcast_o, data_o, done_o} = '0;
	// One command, then the status word unless broadcast
	task send(input logic [4:0] c, input logic b, input logic [15:0] w, input int gap);
		@(posedge ref_clk_i);
		{valid_o, code_o, bcast_o, data_o} <= {1'b1, c, b, w};
		@(posedge ref_clk_i);
		valid_o <= 1'b0;
		data_o <= ~w; // Released word line shows no stale value
		if (!b) begin
			repeat (gap) @(posedge ref_clk_i);
			done_o <= 1'b1; // Status word ends after a prompt or slow gap
			@(posedge ref_clk_i);
			done_o <= 1'b0;
		end
	endtask
endmodule

// ### test/rtmc_mode_actions_tb.sv
// Self-checking bench for the mode-code action block
module rtmc_mode_actions_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, ttag_tick_i = 0, sw_tx_start_i = 0;
	logic mc_valid_i, mc_bcast_i, sw_tx_done_i, ttag_loaded_o, terminal_soft_reset_o, sw_tx_hold_o;
	logic [3:0] reg_addr_i = 0;
	logic [4:0] mc_code_i;
	logic [15:0] reg_wdata_i = 0, mc_data_i, reg_rdata_o, ttag_count_o, tt = 0, d;
	int fail_count = 0, samples_checked = 0, ld_n, rs_n, hd_n, n;
	rtmc_mode_actions dut (.*);
	rtmc_bc_model bc (.ref_clk_i, .valid_o(mc_valid_i), .code_o(mc_code_i), .bcast_o(mc_bcast_i),
		.data_o(mc_data_i), .done_o(sw_tx_done_i));
	initial forever #20 ref_clk_i = ~ref_clk_i;
	// Count output pulses
	always @(posedge ref_clk_i) begin
		ld_n += ttag_loaded_o;
		rs_n += terminal_soft_reset_o;
		hd_n += sw_tx_hold_o;
	end
	function logic exp_ld(input logic [1:0] o, input logic b);
		return o == 2'h0 || o == {b, !b};
	endfunction
	task chk(input string n, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk_i);
		{reg_rd_i, reg_addr_i} <= {1'b1, a};
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk("reg_rdata_o", e, reg_rdata_o);
	endtask
	task conclude;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Sync options with both data bits, then reset options
	initial begin
		void'($urandom(32'h1f2f291d));
		repeat (5) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(4'h0, 16'h0000);
		rd(4'hf, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			wr(4'h0, {12'h0, i[1:0], 2'h0});
			rd(4'h0, {12'h0, i[1:0], 2'h0});
			d = 16'($urandom);
			d[0] = i[2];
			ld_n = 0;
			hd_n = 0;
			bc.send(5'h11, i[3], d, $urandom % 4);
			repeat (2) @(posedge ref_clk_i);
			#1;
			if (exp_ld(i[1:0], d[0])) tt = d;
			chk("ttag_loaded_o", exp_ld(i[1:0], d[0]), ld_n);
			chk("sw_tx_hold_o", !i[3], hd_n);
			chk("ttag_count_o", tt, ttag_count_o);
		end
		// Counter ticks from the last loaded value, then read back
		n = 1 + $urandom % 8;
		repeat (n) begin
			@(posedge ref_clk_i);
			ttag_tick_i <= 1'b1;
		end
		@(posedge ref_clk_i);
		ttag_tick_i <= 1'b0;
		tt = tt + 16'(n);
		#1 chk("ttag_count_o", tt, ttag_count_o);
		rd(4'h1, tt);
		// Mid-run reset clears the options again
		wr(4'h0, 16'h000f);
		@(posedge ref_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(4'h0, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, {15'h0, i[0]});
			rs_n = 0;
			bc.send(5'h08, i[1], 16'($urandom), 1 + $urandom % 4);
			#1 chk("early_reset", 1'b0, rs_n);
			repeat (2) @(posedge ref_clk_i);
			#1 chk("terminal_soft_reset_o", !i[0], rs_n);
		end
		conclude();
	end
endmodule
